// ### logic/mcr_config_regs.v
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_consts.vh"

module mcr_config_regs #(
	parameter [15:0] MAKER_CODE = 16'h5A3C, // Arbitrary value
	parameter TICK_CYC = `MCR_TICK_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [9:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [3:0] sample_valid,
	input wire [3:0] out_of_limit,
	input wire neg_supply_alarm,
	input wire data_available,
	input wire conv_ready,
	output reg irq,
	output wire conversion_select,
	output wire closed_loop_enable,
	output wire grounded_collector_select,
	output wire [2:0] remote_temp_averaging,
	output reg [4:0] sense_filter_k,
	output reg sense_update_tick,
	output reg remote_update_tick,
	output reg data_valid_pin_out,
	output reg data_valid_pin_oe,
	output reg amplifier_enable_pin
);

	reg [15:0] cfg_a;
	reg [15:0] cfg_b;
	reg [4:0] status;
	reg [4:0] mask;
	reg amp_on;
	reg forced_off;
	reg [31:0] rd_val;
	reg rd_hit;
	reg [4:0] next_status;
	reg next_forced_off;
	reg [15:0] pre_cnt;
	reg tick;
	reg [9:0] sns_cnt;
	reg [9:0] sns_lim;
	reg [9:0] rt_cnt;
	reg [9:0] rt_lim;
	reg [4:0] next_k;
	reg [31:0] sns_lim_w;
	reg [31:0] rt_lim_w;
	wire [31:0] tick_full;
	wire [7:0] idx;
	wire setup;
	wire access;
	wire wr;
	wire rd;
	wire [15:0] wmask;
	wire [4:0] rd_clr;
	wire [4:0] evt;
	wire [15:0] tick_last;

	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr = access & pwrite & ~pslverr;
	assign rd = access & ~pwrite;
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	// Parameter arithmetic is 32 bits wide; the prescaler needs only 16
	assign tick_full = TICK_CYC - 1;
	assign tick_last = tick_full[15:0];

	// Configuration bits straight from their flip-flops
	assign conversion_select = cfg_a[`MCR_A_CONVERSION_SELECT];
	assign closed_loop_enable = cfg_a[`MCR_A_LOOP];
	assign grounded_collector_select = cfg_b[`MCR_B_GND_COLL];
	assign remote_temp_averaging = cfg_a[`MCR_A_RTS_HI:`MCR_A_RTS_LO];

	// Read multiplexer; unmapped indices raise an error
	always @* begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		case (idx)
			`MCR_IDX_MAKER: begin
				rd_val = {16'h0000, MAKER_CODE};
			end
			`MCR_IDX_CFG_A: begin
				rd_val = {16'h0000, cfg_a};
			end
			`MCR_IDX_CFG_B: begin
				rd_val = {16'h0000, cfg_b};
			end
			`MCR_IDX_STATUS: begin
				rd_val = {27'h0000000, status};
			end
			`MCR_IDX_MASK: begin
				rd_val = {27'h0000000, mask};
			end
			`MCR_IDX_CTRL: begin
				rd_val = {31'h00000000, amp_on};
			end
			`MCR_IDX_STATE: begin
				rd_val = {24'h000000, data_valid_pin_oe, amplifier_enable_pin,
					forced_off, sense_filter_k};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Bus answer: data and error are caught in setup, ready in access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~rd_hit;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_val;
			end
		end
	end

	// Writable registers; reserved bits are stored as written
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_a <= `MCR_RST_CFG_A;
			cfg_b <= `MCR_RST_CFG_B;
			mask <= 5'h00;
			amp_on <= 1'b0;
		end else if (wr) begin
			case (idx)
				`MCR_IDX_CFG_A: begin
					cfg_a <= (cfg_a & ~wmask) | (pwdata[15:0] & wmask);
				end
				`MCR_IDX_CFG_B: begin
					cfg_b <= (cfg_b & ~wmask) | (pwdata[15:0] & wmask);
				end
				`MCR_IDX_MASK: begin
					if (pstrb[0]) begin
						mask <= pwdata[4:0];
					end
				end
				`MCR_IDX_CTRL: begin
					if (pstrb[0]) begin
						amp_on <= pwdata[0];
					end
				end
				default: begin
					cfg_a <= cfg_a; // Maker code and status ignore writes
				end
			endcase
		end
	end

	// Consecutive-sample alarm filters: 0 channel, 1 local, 2 remote 2, 3 remote 1
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : flt
			wire [8:0] need;
			wire [8:0] run_inc;
			reg [8:0] run;
			if (g == 0) begin : chn
				wire [2:0] code;
				assign code = cfg_b[`MCR_B_CHF_HI:`MCR_B_CHF_LO];
				assign need = (code == 3'h0) ? 9'h001 : (9'h002 << code);
			end else begin : tmp
				wire [1:0] code;
				assign code = cfg_b[7 - 2 * g:6 - 2 * g];
				assign need = 9'h001 << code;
			end
			assign run_inc = run + 9'h001;
			assign evt[g] = sample_valid[g] & out_of_limit[g] & (run_inc >= need);
			// Saturate at the target so a long fault cannot wrap the count
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					run <= 9'h000;
				end else if (sample_valid[g]) begin
					if (!out_of_limit[g]) begin
						run <= 9'h000;
					end else if (run_inc >= need) begin
						run <= need;
					end else begin
						run <= run_inc;
					end
				end
			end
		end
	endgenerate

	// Supply alarm is a level: while it persists a read cannot clear it
	assign evt[`MCR_ST_SUPPLY] = neg_supply_alarm;

	// Read clears only bits the master actually saw; a new set wins
	assign rd_clr = (rd && idx == `MCR_IDX_STATUS) ? prdata[4:0] : 5'h00;

	always @* begin
		next_status = (status & ~rd_clr) | evt;
		next_forced_off = forced_off;
		if (evt[`MCR_ST_SUPPLY] && cfg_b[`MCR_B_CUTOFF]) begin
			next_forced_off = 1'b1;
		end else if (!next_status[`MCR_ST_SUPPLY]) begin
			next_forced_off = 1'b0;
		end
	end

	// Sticky status, interrupt and amplifier cutoff
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 5'h00;
			forced_off <= 1'b0;
			irq <= 1'b0;
			amplifier_enable_pin <= 1'b0;
		end else begin
			status <= next_status;
			forced_off <= next_forced_off;
			irq <= |(next_status & mask);
			amplifier_enable_pin <= amp_on & ~next_forced_off;
		end
	end

	// Shared pin: tri-stated unless enabled, role picks the source
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_valid_pin_oe <= 1'b0;
			data_valid_pin_out <= 1'b0;
		end else begin
			data_valid_pin_oe <= cfg_b[`MCR_B_DAV_EN];
			data_valid_pin_out <= cfg_b[`MCR_B_DAV_SEL] ? conv_ready : data_available;
		end
	end

	// Filter factor and interval limits; invalid codes stop the ticks
	always @* begin
		case (cfg_a[`MCR_A_CSF_HI:`MCR_A_CSF_LO])
			3'h0: begin
				next_k = 5'h01;
				sns_lim_w = `MCR_US2TICK(`MCR_SNS_T0_US);
			end
			3'h1: begin
				next_k = 5'h02;
				sns_lim_w = `MCR_US2TICK(`MCR_SNS_T1_US);
			end
			3'h2: begin
				next_k = 5'h04;
				sns_lim_w = `MCR_US2TICK(`MCR_SNS_T2_US);
			end
			3'h3: begin
				next_k = 5'h08;
				sns_lim_w = `MCR_US2TICK(`MCR_SNS_T3_US);
			end
			3'h4: begin
				next_k = 5'h10;
				sns_lim_w = `MCR_US2TICK(`MCR_SNS_T4_US);
			end
			default: begin
				next_k = 5'h00;
				sns_lim_w = 32'h00000000;
			end
		endcase
		case (cfg_a[`MCR_A_RTS_HI:`MCR_A_RTS_LO])
			3'h0: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T0_MS);
			3'h1: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T1_MS);
			3'h2: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T2_MS);
			3'h3: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T3_MS);
			3'h4: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T4_MS);
			3'h5: rt_lim_w = `MCR_MS2TICK(`MCR_RT_T5_MS);
			default: rt_lim_w = 32'h00000000;
		endcase
		// Longest interval is 980 ticks, so ten bits are enough
		sns_lim = sns_lim_w[9:0];
		rt_lim = rt_lim_w[9:0];
	end

	// Base tick prescaler keeps interval counters narrow
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (pre_cnt >= tick_last) begin
			pre_cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	// Update interval counters; a changed code applies at once to the running count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sns_cnt <= 10'h000;
			rt_cnt <= 10'h000;
			sense_update_tick <= 1'b0;
			remote_update_tick <= 1'b0;
			sense_filter_k <= 5'h08;
		end else begin
			sense_filter_k <= next_k;
			sense_update_tick <= 1'b0;
			remote_update_tick <= 1'b0;
			if (tick && sns_lim != 10'h000) begin
				if (sns_cnt + 10'h001 >= sns_lim) begin
					sns_cnt <= 10'h000;
					sense_update_tick <= 1'b1;
				end else begin
					sns_cnt <= sns_cnt + 10'h001;
				end
			end
			if (tick && rt_lim != 10'h000) begin
				if (rt_cnt + 10'h001 >= rt_lim) begin
					rt_cnt <= 10'h000;
					remote_update_tick <= 1'b1;
				end else begin
					rt_cnt <= rt_cnt + 10'h001;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ### logic/mcr_consts.vh
// Operation
// - A 16-bit read-only maker code register; writes never change it.
// - Bit 12 of config A: 0 autonomous conversion, 1 direct-mode conversion; resets 0.
// - Config A bits 10-8, reset 011, give sense filter factor 1,2,4,8,16.
// - Sense update interval 0.2, 3.4, 6.6, 13, 25.6 ms per valid code.
// - Config A bits 6-4 give remote update 16,16,18,26,50,98 ms; others invalid.
// - Config A bit 0 set enables closed-loop current control; reset clear.
// - Config B bit 15 set drives the data valid pin, else high impedance.
// - Config B bit 14: 0 data-available output, 1 converter-ready output.
// - Channel alarm needs 1,4,8,...,256 consecutive bad samples; reset code 011.
// - Config B bit 7 set selects PNP mode for both remote sensors.
// - Config B bit 6 set, its reset, lets supply alarm force amplifier off.
// - Amplifier stays off until the supply alarm has been cleared by software.
// - With bit 6 clear the supply alarm leaves the amplifier pin alone.
// - Local temperature alarm needs 1,2,4,8 bad samples; bits 5-4, reset 10.
// - Reserved config bits reset to zero and are kept as written.
// - Remote alarm filters at bits 3-2 and 1-0, reset 10, need 1-8 samples.
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// Register indices; byte address is four times the index
`define MCR_IDX_MAKER 8'h0C
`define MCR_IDX_CFG_A 8'h10
`define MCR_IDX_CFG_B 8'h11
`define MCR_IDX_STATUS 8'h60
`define MCR_IDX_MASK 8'h61
`define MCR_IDX_CTRL 8'h62
`define MCR_IDX_STATE 8'h63

// Reset values
`define MCR_RST_CFG_A 16'h0300
`define MCR_RST_CFG_B 16'h036A

// Field positions, config A
`define MCR_A_CONVERSION_SELECT 12
`define MCR_A_CSF_HI 10
`define MCR_A_CSF_LO 8
`define MCR_A_RTS_HI 6
`define MCR_A_RTS_LO 4
`define MCR_A_LOOP 0

// Field positions, config B
`define MCR_B_DAV_EN 15
`define MCR_B_DAV_SEL 14
`define MCR_B_CHF_HI 10
`define MCR_B_CHF_LO 8
`define MCR_B_GND_COLL 7
`define MCR_B_CUTOFF 6

// Status bit of the negative supply alarm
`define MCR_ST_SUPPLY 4

// Timing: clock period and interval tick
`define MCR_CLK_NS 50
`define MCR_TICK_US 100
`define MCR_TICK_CYC ((`MCR_TICK_US * 1000) / `MCR_CLK_NS)

// Sense update intervals in microseconds, then in ticks
`define MCR_SNS_T0_US 200
`define MCR_SNS_T1_US 3400
`define MCR_SNS_T2_US 6600
`define MCR_SNS_T3_US 13000
`define MCR_SNS_T4_US 25600
`define MCR_US2TICK(t) ((t) / `MCR_TICK_US)

// Remote update intervals in milliseconds, then in ticks
`define MCR_RT_T0_MS 16
`define MCR_RT_T1_MS 16
`define MCR_RT_T2_MS 18
`define MCR_RT_T3_MS 26
`define MCR_RT_T4_MS 50
`define MCR_RT_T5_MS 98
`define MCR_MS2TICK(t) (((t) * 1000) / `MCR_TICK_US)

`endif

// ### verification/mcr_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_chk_monitor #(
	parameter TICK_CYC = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire data_available,
	input wire conv_ready,
	input wire data_valid_pin_out,
	input wire data_valid_pin_oe,
	input wire [4:0] sense_filter_k,
	input wire sense_update_tick,
	input wire remote_update_tick
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	// Role only matters when the two sources differ
	chk_pin_follow: assert property (data_valid_pin_oe && $past(data_available) == $past(conv_ready)
		|-> data_valid_pin_out == $past(data_available))
		else $error("pin level wrong");
	chk_k_legal: assert property (sense_filter_k inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
		else $error("bad filter factor");
	chk_sense_pulse: assert property (sense_update_tick |=> !sense_update_tick)
		else $error("sense tick held");
	chk_remote_pulse: assert property (remote_update_tick |=> !remote_update_tick)
		else $error("remote tick held");
endmodule
bind mcr_config_regs mcr_chk_monitor #(.TICK_CYC(TICK_CYC)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .data_available(data_available),
	.conv_ready(conv_ready), .data_valid_pin_out(data_valid_pin_out), .data_valid_pin_oe(data_valid_pin_oe),
	.sense_filter_k(sense_filter_k), .sense_update_tick(sense_update_tick),
	.remote_update_tick(remote_update_tick));
`default_nettype wire

// ### verification/tb_monitor_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_config_registers;
	localparam int TK = 4;
	localparam logic [15:0] MK = 16'h2B7E; // Arbitrary maker code
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic nsa = '0, data_available_output = '0, crdy = '0, e;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0, q;
	logic [3:0] sv = '0, ool = '0;
	wire [31:0] prdata;
	wire pready, pslverr, irq, cs, cle, gcs, sut, rut, dvo, dvoe, amp;
	wire [2:0] rta;
	wire [4:0] k;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	mcr_config_regs #(.MAKER_CODE(MK), .TICK_CYC(TK)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_valid(sv), .out_of_limit(ool), .neg_supply_alarm(nsa),
		.data_available(data_available_output), .conv_ready(crdy), .irq(irq), .conversion_select(cs), .closed_loop_enable(cle),
		.grounded_collector_select(gcs), .remote_temp_averaging(rta), .sense_filter_k(k),
		.sense_update_tick(sut), .remote_update_tick(rut), .data_valid_pin_out(dvo),
		.data_valid_pin_oe(dvoe), .amplifier_enable_pin(amp));
	always #25 pclk = ~pclk;
	// Hang guard, well above the longest tick period measured
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("Error %s: expected %h, seen %h", nm, x, g);
		end
	endtask
	// One bus transfer; waits for ready instead of assuming a latency
	task automatic apb(input logic [9:0] a, input logic w, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] x);
		apb(a, 1'b0, 16'h0000);
		chk("prdata", x, q);
	endtask
	// One sample strobe on group g
	task automatic smp(input int g, input logic b);
		@(posedge pclk);
		sv <= 4'h1 << g;
		ool <= {3'h0, b} << g;
		@(posedge pclk);
		sv <= 4'h0;
	endtask
	task automatic t_regs;
		@(posedge pclk) #1;
		chk("k", 32'h8, k);
		chk("outs", 32'h0, {cs, cle, gcs, rta, dvoe});
		rd(10'h040, 32'h0300);
		rd(10'h044, 32'h036A);
		rd(10'h030, MK);
		apb(10'h030, 1'b1, 16'hFFFF);
		rd(10'h030, MK);
		apb(10'h3FC, 1'b0, 16'h0000);
		chk("pslverr", 32'h1, e);
	endtask
	// Every smoothing and averaging code, with mode bits and some reserved bits set
	task automatic t_cfga;
		logic [15:0] d;
		for (logic [3:0] c = 0; c < 8; c++) begin
			d = {3'h5, 2'h3, c[2:0], 1'h0, c[2:0], 4'hB};
			apb(10'h040, 1'b1, d);
			rd(10'h040, {16'h0000, d});
			chk("k", c < 5 ? 32'h1 << c : 32'h0, k);
			chk("outs", {2'h3, 1'b0, c[2:0]}, {cs, cle, gcs, rta});
		end
		apb(10'h040, 1'b1, 16'h0000);
		@(posedge pclk) #1 chk("outs", 32'h0, {cs, cle});
	endtask
	task automatic t_pin;
		apb(10'h044, 1'b1, 16'hC0EA);
		crdy <= 1'b1;
		repeat (2) @(posedge pclk);
		#1 chk("pin", 32'h7, {dvoe, dvo, gcs});
		data_available_output <= 1'b1;
		crdy <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 chk("pin", 32'h2, {dvoe, dvo});
		apb(10'h044, 1'b1, 16'h80EA);
		repeat (2) @(posedge pclk);
		#1 chk("pin", 32'h3, {dvoe, dvo});
		apb(10'h044, 1'b1, 16'h40EA);
		repeat (2) @(posedge pclk);
		#1 chk("pin", 32'h0, dvoe);
	endtask
	// A broken run, then an unbroken run of n bad samples
	task automatic filt(input int g, input int sh, input logic [3:0] c, input int n);
		apb(10'h044, 1'b1, 16'h0040 | (16'(c) << sh));
		apb(10'h180, 1'b0, 16'h0000);
		smp(g, 1'b0); // Clear the count left by the previous code
		repeat (n - 1) smp(g, 1'b1);
		smp(g, 1'b0);
		repeat (n - 1) smp(g, 1'b1);
		#1 chk("irq", 32'h0, irq);
		smp(g, 1'b1);
		#1 chk("irq", 32'h1, irq);
		rd(10'h180, 32'h1 << g);
		@(posedge pclk) #1 chk("irq", 32'h0, irq);
	endtask
	task automatic t_filts;
		apb(10'h184, 1'b1, 16'h001F);
		for (int c = 0; c < 8; c++)
			filt(0, 8, 4'(c), c == 0 ? 1 : 1 << (c + 1));
		for (int g = 1; g < 4; g++)
			for (int c = 0; c < 4; c++)
				filt(g, 6 - 2 * g, 4'(c), 1 << c);
		apb(10'h184, 1'b1, 16'h0000);
		smp(1, 1'b1);
		#1 chk("irq", 32'h0, irq);
		rd(10'h180, 32'h2);
	endtask
	// Forced cutoff holds until the alarm is read away
	task automatic t_sup;
		apb(10'h188, 1'b1, 16'h0001);
		@(posedge pclk) #1 chk("amp", 32'h1, amp);
		nsa <= 1'b1;
		@(posedge pclk) #1;
		nsa <= 1'b0;
		chk("amp", 32'h0, amp);
		repeat (4) @(posedge pclk);
		#1 chk("amp", 32'h0, amp);
		rd(10'h18C, 32'h21);
		rd(10'h180, 32'h10);
		#1 chk("amp", 32'h1, amp);
		apb(10'h044, 1'b1, 16'h0000);
		nsa <= 1'b1;
		@(posedge pclk) #1;
		nsa <= 1'b0;
		@(posedge pclk) #1 chk("amp", 32'h1, amp);
		rd(10'h180, 32'h10);
	endtask
	// Gap between two pulses; the first pulse may belong to the old setting
	task automatic per(input logic r, input int x);
		int c = 0;
		do @(posedge pclk); while ((r ? rut : sut) !== 1'b1);
		do begin
			@(posedge pclk);
			c++;
		end while ((r ? rut : sut) !== 1'b1);
		chk("period", x, c);
	endtask
	task automatic t_tick;
		per(1'b0, 2 * TK);
		per(1'b1, 160 * TK);
		apb(10'h040, 1'b1, 16'h0450);
		per(1'b0, 256 * TK);
		per(1'b1, 980 * TK);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_cfga;
		t_pin;
		t_filts;
		t_sup;
		t_tick;
		complete_run;
	end
endmodule
`default_nettype wire
